// [logic/swc_pkg.sv]
package swc_pkg;
  // APB register map
  localparam logic [7:0] SWC_CTRL_OFS = 8'h00;
  localparam logic [7:0] SWC_WAKE_EN_OFS = 8'h04;
  localparam logic [7:0] SWC_SLEEP_STAT_OFS = 8'h08;
  localparam logic [7:0] SWC_IRQ_STAT_OFS = 8'h0c;
  localparam logic [7:0] SWC_IRQ_MASK_OFS = 8'h10;

  // Control register fields
  localparam int SWC_CTRL_WDT_EN_BIT = 0;
  localparam logic [31:0] SWC_CTRL_RESET = 32'h0000_0000;

  // Wake enable fields: ext pin, port change, then peripherals
  localparam int SWC_WEN_EXT_BIT = 0;
  localparam int SWC_WEN_PCH_BIT = 1;
  localparam int SWC_WEN_PER_LSB = 2;
  localparam int SWC_NUM_PERIPH = 9;
  localparam int SWC_WEN_W = SWC_WEN_PER_LSB + SWC_NUM_PERIPH;
  localparam logic [SWC_WEN_W-1:0] SWC_WEN_RESET = 11'h000;

  // Sleep status fields
  localparam int SWC_ST_ASLEEP_BIT = 0;
  localparam int SWC_ST_PD_BIT = 3;
  localparam int SWC_ST_TO_BIT = 4;
  localparam logic SWC_PD_RESET = 1'b1;
  localparam logic SWC_TO_RESET = 1'b1;

  // Interrupt status fields
  localparam int SWC_IRQ_EXT_BIT = 0;
  localparam int SWC_IRQ_PCH_BIT = 1;
  localparam int SWC_IRQ_WDT_BIT = 2;
  localparam int SWC_IRQ_WAKE_BIT = 3;
  localparam int SWC_IRQ_MASTER_CLEAR_PIN_BIT = 4;
  localparam int SWC_IRQ_NOP_BIT = 5;
  localparam int SWC_IRQ_W = 6;
  localparam logic [SWC_IRQ_W-1:0] SWC_IRQ_RESET = 6'h00;

  // Port and program counter widths
  localparam int SWC_PORT_W = 8;
  localparam int SWC_PORTB_W = 4;
  localparam int SWC_PC_W = 13;
  localparam logic [SWC_PC_W-1:0] SWC_IRQ_VECTOR = 13'h0004;
  localparam logic [SWC_PC_W-1:0] SWC_PC_RESET = 13'h0000;

  // Watchdog period
  localparam int SWC_CLK_HZ = 50_000_000;
  localparam int SWC_WDT_PERIOD_MS = 18;
  localparam int SWC_WDT_CYCLES = SWC_CLK_HZ / 1000 * SWC_WDT_PERIOD_MS;
  localparam int SWC_WDT_W = 24;

  typedef enum logic [1:0] {
    SWC_RUN,
    SWC_ASLEEP,
    SWC_WAKE_EXEC
  } swc_state_t;
endpackage

// [logic/swc_pin_sync.sv]
`timescale 1ns/1ps
module swc_pin_sync #(
  parameter int W = 1
) (
  input wire logic mclk_i, // System clock
  input wire logic reset_i, // Synchronous reset
  input wire logic [W-1:0] pin_i, // Asynchronous pins
  output logic [W-1:0] level_o // Qualified levels
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end
    else
    begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Level moves only when the two later stages agree
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      level_o <= '0;
    else
    begin
      for (int i = 0; i < W; i++)
      begin
        if (stage2[i] == stage3[i])
          level_o[i] <= stage3[i];
      end
    end
  end
endmodule

// [logic/swc_sleep_ctrl.sv]
// Contract
// RULE1: Sleep entered only by sleep instruction
// RULE2: Entry clears watchdog, PD low, TO high, oscillator off
// RULE3: Ports hold pre-sleep drive during sleep
// RULE4: Wake on reset pin, watchdog, interrupts
// RULE5: Reset pin resets; others continue execution
// RULE6: PD set at power-up, cleared on sleep
// RULE7: Watchdog wake clears TO
// RULE8: Listed peripheral interrupts can wake device
// RULE9: Clocked peripherals raise nothing while asleep
// RULE10: Prefetch next address during sleep instruction
// RULE11: Source enable needed; global enable ignored
// RULE12: Global enable clear: continue after sleep
// RULE13: Global enable set: one instruction, then vector
// RULE14: Pending interrupt makes sleep a no-operation
// RULE15: Interrupt during sleep: finish entry, wake
// RULE16: Software puts no-op after sleep
// RULE17: Software clears watchdog before sleep
// RULE18: Reset pin held high throughout sleep
// RULE19: Wake detection combinational from enable and flags
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module swc_sleep_ctrl
  import swc_pkg::*;
#(
  parameter int WDT_CYCLES = SWC_WDT_CYCLES
) (
  input wire logic mclk_i, // 50 MHz clock
  input wire logic reset_i, // Power-on reset, sync high
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB direction
  input wire logic [7:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error
  output logic irq_o, // Level interrupt
  input wire logic sleep_exec_i, // Core executes sleep, pulse
  input wire logic watchdog_clear_instruction_i, // Core executes watchdog clear, pulse
  input wire logic instr_done_i, // Core finished an instruction, pulse
  input wire logic global_irq_enable_i, // Core global enable
  input wire logic [SWC_PC_W-1:0] program_counter_i, // Address of current instruction
  input wire logic master_clear_pin_n_i, // Reset pin, low active
  input wire logic external_irq_pin_i, // External interrupt pin
  input wire logic [SWC_PORTB_W-1:0] portb_pin_i, // Port-change pins
  input wire logic [SWC_NUM_PERIPH-1:0] periph_wake_flag_i, // Sleep-capable flags
  input wire logic periph_clocked_flag_i, // Flags of clocked peripherals
  input wire logic [SWC_PORT_W-1:0] port_out_i, // Core port data
  input wire logic [SWC_PORT_W-1:0] port_oe_i, // Core port enables
  output logic [SWC_PORT_W-1:0] port_out_o, // Pad data
  output logic [SWC_PORT_W-1:0] port_oe_o, // Pad enables
  output logic osc_drive_o, // Oscillator driver on
  output logic core_reset_o, // Full device reset
  output logic wdt_reset_o, // Watchdog reset while running, pulse
  output logic sleep_nop_o, // Sleep taken as no-op, pulse
  output logic wake_o, // Wake request, combinational
  output logic resume_o, // Continue execution, pulse
  output logic [SWC_PC_W-1:0] fetch_addr_o, // Address to fetch
  output logic vector_req_o, // Branch to vector, pulse
  output logic [SWC_PC_W-1:0] vector_addr_o, // Interrupt vector
  output logic core_irq_o, // Enabled interrupt to core
  output logic power_down_flag_o, // Status bit 3
  output logic timeout_flag_o // Status bit 4
);
  localparam logic [SWC_WDT_W-1:0] WDT_LAST = SWC_WDT_W'(WDT_CYCLES - 1);

  swc_state_t state;
  logic ext_lvl;
  logic ext_lvl_q;
  logic master_clear_pin_n_lvl;
  logic [SWC_PORTB_W-1:0] pb_lvl;
  logic [SWC_PORTB_W-1:0] pb_lvl_q;
  logic wdt_en;
  logic [SWC_WEN_W-1:0] wake_en;
  logic [SWC_IRQ_W-1:0] irq_stat;
  logic [SWC_IRQ_W-1:0] irq_mask;
  logic [SWC_IRQ_W-1:0] irq_snap;
  logic [SWC_IRQ_W-1:0] irq_set;
  logic [SWC_IRQ_W-1:0] irq_clr;
  logic [SWC_WDT_W-1:0] wdt_cnt;
  logic wdt_tick;
  logic ext_flag;
  logic pch_flag;
  logic pending;
  logic asleep;
  logic master_clear_pin_active;
  logic enter_sleep;
  logic nop_sleep;
  logic wdt_wake;
  logic int_wake;
  logic setup_ph;
  logic access_ph;
  logic addr_ok;
  logic irq_read;

  swc_pin_sync #(
    .W(SWC_PORTB_W + 2)
  ) u_sync (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .pin_i({portb_pin_i, external_irq_pin_i, master_clear_pin_n_i}),
    .level_o({pb_lvl, ext_lvl, master_clear_pin_n_lvl})
  );

  assign asleep = (state == SWC_ASLEEP);
  assign master_clear_pin_active = ~master_clear_pin_n_lvl;
  assign ext_flag = irq_stat[SWC_IRQ_EXT_BIT];
  assign pch_flag = irq_stat[SWC_IRQ_PCH_BIT];

  // Enabled pending interrupt, no clock needed
  assign pending = (ext_flag & wake_en[SWC_WEN_EXT_BIT]) // RULE11
    | (pch_flag & wake_en[SWC_WEN_PCH_BIT])
    | (|(periph_wake_flag_i & wake_en[SWC_WEN_PER_LSB +: SWC_NUM_PERIPH])); // RULE8
  assign core_irq_o = pending | (periph_clocked_flag_i & ~asleep); // RULE9

  assign wdt_tick = wdt_en & (wdt_cnt == WDT_LAST);
  assign nop_sleep = (state == SWC_RUN) & sleep_exec_i & pending & ~master_clear_pin_active; // RULE14
  assign enter_sleep = (state == SWC_RUN) & sleep_exec_i & ~pending & ~master_clear_pin_active; // RULE1
  assign int_wake = asleep & pending; // RULE15
  assign wdt_wake = asleep & wdt_tick & ~pending; // RULE4
  assign wake_o = int_wake | wdt_wake; // RULE19

  // Sleep sequencing
  always_ff @(posedge mclk_i)
  begin
    if (reset_i || master_clear_pin_active) // RULE5
      state <= SWC_RUN;
    else
    begin
      case (state)
        SWC_RUN:
        begin
          if (enter_sleep)
            state <= SWC_ASLEEP;
        end
        SWC_ASLEEP:
        begin
          if (wake_o && global_irq_enable_i)
            state <= SWC_WAKE_EXEC; // RULE13
          else if (wake_o)
            state <= SWC_RUN; // RULE12
        end
        SWC_WAKE_EXEC:
        begin
          if (instr_done_i)
            state <= SWC_RUN;
        end
        default:
          state <= SWC_RUN;
      endcase
    end
  end

  // Core-facing pulses
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      resume_o <= 1'b0;
      vector_req_o <= 1'b0;
      sleep_nop_o <= 1'b0;
      wdt_reset_o <= 1'b0;
    end
    else
    begin
      resume_o <= wake_o & ~master_clear_pin_active; // RULE5
      vector_req_o <= (state == SWC_WAKE_EXEC) & instr_done_i & ~master_clear_pin_active; // RULE13
      sleep_nop_o <= nop_sleep;
      wdt_reset_o <= (state != SWC_ASLEEP) & wdt_tick & ~master_clear_pin_active;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      fetch_addr_o <= SWC_PC_RESET;
    else if (sleep_exec_i && state == SWC_RUN)
      fetch_addr_o <= program_counter_i + SWC_PC_W'(1); // RULE10
  end

  assign vector_addr_o = SWC_IRQ_VECTOR;

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      core_reset_o <= 1'b1;
    else
      core_reset_o <= master_clear_pin_active; // RULE5
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      osc_drive_o <= 1'b1;
    else if (enter_sleep)
      osc_drive_o <= 1'b0; // RULE2
    else if (wake_o || master_clear_pin_active)
      osc_drive_o <= 1'b1;
  end

  // Pads keep pre-sleep drive
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      port_out_o <= '0;
      port_oe_o <= '0;
    end
    else if (!asleep || master_clear_pin_active)
    begin
      port_out_o <= port_out_i; // RULE3
      port_oe_o <= port_oe_i;
    end
  end

  // Watchdog keeps running in sleep
  always_ff @(posedge mclk_i)
  begin
    if (reset_i || master_clear_pin_active || !wdt_en)
      wdt_cnt <= '0;
    else if (watchdog_clear_instruction_i || enter_sleep || wdt_tick)
      wdt_cnt <= '0; // RULE2
    else
      wdt_cnt <= wdt_cnt + SWC_WDT_W'(1);
  end

  // Power-down flag survives the reset pin
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      power_down_flag_o <= SWC_PD_RESET; // RULE6
    else if (enter_sleep)
      power_down_flag_o <= 1'b0; // RULE6
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      timeout_flag_o <= SWC_TO_RESET;
    else if (enter_sleep)
      timeout_flag_o <= 1'b1; // RULE2
    else if (wdt_tick && !master_clear_pin_active)
      timeout_flag_o <= 1'b0; // RULE7
  end

  // Edge history for event detection
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      ext_lvl_q <= 1'b0;
      pb_lvl_q <= '0;
    end
    else
    begin
      ext_lvl_q <= ext_lvl;
      pb_lvl_q <= pb_lvl;
    end
  end

  // APB slave
  assign setup_ph = psel_i & ~penable_i;
  assign access_ph = psel_i & penable_i;
  assign pready_o = 1'b1;
  assign addr_ok = (paddr_i == SWC_CTRL_OFS) | (paddr_i == SWC_WAKE_EN_OFS)
    | (paddr_i == SWC_SLEEP_STAT_OFS) | (paddr_i == SWC_IRQ_STAT_OFS)
    | (paddr_i == SWC_IRQ_MASK_OFS);
  assign pslverr_o = access_ph & ~addr_ok;
  assign irq_read = access_ph & ~pwrite_i & (paddr_i == SWC_IRQ_STAT_OFS);

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      prdata_o <= '0;
      irq_snap <= '0;
    end
    else if (setup_ph)
    begin
      prdata_o <= '0;
      irq_snap <= '0;
      case (paddr_i)
        SWC_CTRL_OFS:
          prdata_o[SWC_CTRL_WDT_EN_BIT] <= wdt_en;
        SWC_WAKE_EN_OFS:
          prdata_o[SWC_WEN_W-1:0] <= wake_en;
        SWC_SLEEP_STAT_OFS:
        begin
          prdata_o[SWC_ST_ASLEEP_BIT] <= asleep;
          prdata_o[SWC_ST_PD_BIT] <= power_down_flag_o;
          prdata_o[SWC_ST_TO_BIT] <= timeout_flag_o;
        end
        SWC_IRQ_STAT_OFS:
        begin
          prdata_o[SWC_IRQ_W-1:0] <= irq_stat;
          irq_snap <= irq_stat;
        end
        SWC_IRQ_MASK_OFS:
          prdata_o[SWC_IRQ_W-1:0] <= irq_mask;
        default:
          prdata_o <= '0;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      wdt_en <= SWC_CTRL_RESET[SWC_CTRL_WDT_EN_BIT];
    else if (access_ph && pwrite_i && paddr_i == SWC_CTRL_OFS)
      wdt_en <= pwdata_i[SWC_CTRL_WDT_EN_BIT];
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      wake_en <= SWC_WEN_RESET;
    else if (access_ph && pwrite_i && paddr_i == SWC_WAKE_EN_OFS)
      wake_en <= pwdata_i[SWC_WEN_W-1:0];
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      irq_mask <= SWC_IRQ_RESET;
    else if (access_ph && pwrite_i && paddr_i == SWC_IRQ_MASK_OFS)
      irq_mask <= pwdata_i[SWC_IRQ_W-1:0];
  end

  // Sticky events; set wins over read-clear
  always_comb
  begin
    irq_set = '0;
    irq_set[SWC_IRQ_EXT_BIT] = ext_lvl & ~ext_lvl_q; // RULE4
    irq_set[SWC_IRQ_PCH_BIT] = |(pb_lvl ^ pb_lvl_q); // RULE4
    irq_set[SWC_IRQ_WDT_BIT] = wdt_wake;
    irq_set[SWC_IRQ_WAKE_BIT] = wake_o;
    irq_set[SWC_IRQ_MASTER_CLEAR_PIN_BIT] = master_clear_pin_active;
    irq_set[SWC_IRQ_NOP_BIT] = nop_sleep;
    irq_clr = irq_read ? irq_snap : '0;
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      irq_stat <= SWC_IRQ_RESET;
    else
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
  end

  assign irq_o = |(irq_stat & irq_mask);
endmodule

// [tb/swc_properties.sv]
`timescale 1ns/1ps
module swc_chk
  import swc_pkg::*;
#(
  parameter int WDT_CYCLES = 64
) (
  input wire logic mclk_i, // Clock
  input wire logic reset_i, // Reset
  input wire logic sleep_exec_i, // Sleep pulse
  input wire logic instr_done_i, // Done pulse
  input wire logic global_irq_enable_i, // Global enable
  input wire logic [SWC_PC_W-1:0] program_counter_i, // Sleep address
  input wire logic master_clear_pin_n_i, // Reset pin
  input wire logic [SWC_PORT_W-1:0] port_out_o, // Pad data
  input wire logic osc_drive_o, // Oscillator on
  input wire logic core_reset_o, // Device reset
  input wire logic sleep_nop_o, // Sleep no-op
  input wire logic wake_o, // Wake request
  input wire logic resume_o, // Resume pulse
  input wire logic [SWC_PC_W-1:0] fetch_addr_o, // Prefetch address
  input wire logic vector_req_o, // Vector pulse
  input wire logic power_down_flag_o, // Power-down flag
  input wire logic timeout_flag_o // Timeout flag
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_enter;
    sleep_exec_i ##1 $fell(osc_drive_o);
  endsequence
  sequence s_wake_gie;
    wake_o && global_irq_enable_i ##1 resume_o;
  endsequence
  a_enter_flags: assert property (s_enter |-> !power_down_flag_o && timeout_flag_o)
    else $error("entry flags wrong");
  a_sleep_cause: assert property ($fell(osc_drive_o) |-> $past(sleep_exec_i))
    else $error("sleep without instruction");
  a_wake_resume: assert property (wake_o |=> resume_o)
    else $error("wake without resume");
  a_gie_vector: assert property (s_wake_gie ##1 instr_done_i |=> vector_req_o)
    else $error("vector missing");
  a_vector_cause: assert property (vector_req_o |-> $past(instr_done_i))
    else $error("vector without instruction");
  a_nop_keeps:
    assert property (sleep_nop_o |-> osc_drive_o && $stable(power_down_flag_o))
    else $error("no-op sleep changed state");
  a_ports_hold:
    assert property (!osc_drive_o && !$past(osc_drive_o) |-> $stable(port_out_o))
    else $error("ports moved while asleep");
  a_fetch_next:
    assert property (sleep_exec_i && osc_drive_o && !core_reset_o
      |=> fetch_addr_o == $past(program_counter_i) + 13'h0001)
    else $error("prefetch address wrong");
  a_master_clear_pin_reset: assert property (!master_clear_pin_n_i [*8] |-> core_reset_o)
    else $error("reset pin ignored");
endmodule

// [tb/swc_core_model.sv]
`timescale 1ns/1ps
module swc_core_model (
  input wire logic mclk_i, // Clock
  input wire logic reset_i, // Reset
  input wire logic go_i, // Sleep request
  input wire logic slow_i, // Late completion
  input wire logic resume_i, // Resume pulse
  output logic watchdog_clear_instruction_o, // Watchdog clear
  output logic sleep_exec_o, // Sleep pulse
  output logic instr_done_o // Done pulse
);
  logic [2:0] pend;
  always_ff @(posedge mclk_i)
  begin
    // Watchdog clear always precedes sleep
    watchdog_clear_instruction_o <= go_i && !reset_i;
    sleep_exec_o <= watchdog_clear_instruction_o && !reset_i;
  end
  always_ff @(posedge mclk_i)
  begin
    // Instruction after sleep is a no-op
    pend <= reset_i ? 3'h0 : {pend[1:0], resume_i};
    instr_done_o <= !reset_i && (slow_i ? pend[2] : resume_i);
  end
endmodule

// [tb/swc_sleep_ctrl_tb_top.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error %0t: got %h exp %h", $time, a, b); end end
module swc_sleep_ctrl_tb_top;
  import swc_pkg::*;
  localparam int WDT = 64;
  logic mclk_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic pready_o, pslverr_o, irq_o, sleep_exec_i, watchdog_clear_instruction_i, instr_done_i, err;
  logic global_irq_enable_i = 1'b0, master_clear_pin_n_i = 1'b1, external_irq_pin_i = 1'b0;
  logic [SWC_PC_W-1:0] program_counter_i = 13'h0000, fetch_addr_o, vector_addr_o;
  logic [SWC_PORTB_W-1:0] portb_pin_i = 4'h0;
  logic [SWC_NUM_PERIPH-1:0] periph_wake_flag_i = 9'h000;
  logic [SWC_PORT_W-1:0] port_out_i = 8'h00, port_oe_i = 8'h00, port_out_o, port_oe_o;
  logic [15:0] pv;
  logic periph_clocked_flag_i = 1'b0, osc_drive_o, core_reset_o, wdt_reset_o, sleep_nop_o;
  logic wake_o, resume_o, vector_req_o, core_irq_o, power_down_flag_o, timeout_flag_o;
  logic go = 1'b0, slow = 1'b0;
  int vec_cnt = 0;
  int vec_base = 0;
  int error_cnt = 0;
  int checks_done = 0;
  swc_sleep_ctrl #(.WDT_CYCLES(WDT)) dut (.*);
  swc_core_model u_core (.mclk_i(mclk_i), .reset_i(reset_i), .go_i(go), .slow_i(slow),
    .resume_i(resume_o), .watchdog_clear_instruction_o(watchdog_clear_instruction_i), .sleep_exec_o(sleep_exec_i),
    .instr_done_o(instr_done_i));
  initial
  begin
    forever #10 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i)
  begin
    if (vector_req_o === 1'b1)
      vec_cnt <= vec_cnt + 1;
  end
  function automatic logic [31:0] stat(input logic pd, input logic to);
    stat = 32'h0;
    stat[SWC_ST_PD_BIT] = pd;
    stat[SWC_ST_TO_BIT] = to;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    `CHK(pready_o, 1'b1)
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    #1;
  endtask
  task automatic do_sleep();
    @(posedge mclk_i);
    go <= 1'b1;
    program_counter_i <= 13'($urandom);
    @(posedge mclk_i);
    go <= 1'b0;
    repeat (2) @(posedge mclk_i);
  endtask
  task automatic wait_wake();
    int n;
    n = 0;
    while (wake_o !== 1'b1 && n < 100)
    begin
      // Wake stands for one cycle only
      @(negedge mclk_i);
      n++;
    end
  endtask
  task automatic settle();
    @(posedge mclk_i);
    periph_wake_flag_i <= 9'h000;
    external_irq_pin_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
    apb(1'b0, SWC_IRQ_STAT_OFS, 32'h0);
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #100us;
    `CHK(1'b0, 1'b1)
    end_sim();
  end
  initial
  begin
    rd = $urandom(39540);
    repeat (10) @(posedge mclk_i);
    reset_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    apb(1'b0, SWC_SLEEP_STAT_OFS, 32'h0);
    `CHK(rd, stat(1'b1, 1'b1))
    apb(1'b0, 8'h14, 32'h0);
    `CHK({err, rd}, 33'h1_0000_0000)
    apb(1'b1, SWC_WAKE_EN_OFS, 32'h7ff);
    @(posedge mclk_i);
    periph_wake_flag_i <= 9'h001;
    do_sleep();
    repeat (3) @(posedge mclk_i);
    #1;
    `CHK({osc_drive_o, irq_o}, 2'b10)
    apb(1'b1, SWC_IRQ_MASK_OFS, 32'h3f);
    `CHK(irq_o, 1'b1)
    apb(1'b0, SWC_SLEEP_STAT_OFS, 32'h0);
    `CHK(rd, stat(1'b1, 1'b1))
    apb(1'b0, SWC_IRQ_STAT_OFS, 32'h0);
    `CHK({rd[SWC_IRQ_NOP_BIT], irq_o}, 2'b10)
    settle();
    for (int i = 0; i < 11; i++)
    begin
      @(posedge mclk_i);
      global_irq_enable_i <= 1'($urandom);
      slow <= 1'($urandom);
      pv = 16'($urandom);
      {port_out_i, port_oe_i} <= pv;
      vec_base = vec_cnt;
      do_sleep();
      #1;
      `CHK({osc_drive_o, power_down_flag_o, timeout_flag_o}, 3'b001)
      `CHK(fetch_addr_o, program_counter_i + 13'h0001)
      @(posedge mclk_i);
      {port_out_i, port_oe_i} <= ~pv;
      periph_clocked_flag_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      #1;
      `CHK({wake_o, core_irq_o, port_out_o, port_oe_o}, {2'b00, pv})
      @(posedge mclk_i);
      periph_clocked_flag_i <= 1'b0;
      if (i < 9)
        periph_wake_flag_i <= 9'h001 << i;
      else if (i == 9)
        external_irq_pin_i <= 1'b1;
      else
        portb_pin_i <= ~portb_pin_i;
      wait_wake();
      `CHK(wake_o, 1'b1)
      settle();
      `CHK({vec_cnt != vec_base, osc_drive_o}, {global_irq_enable_i, 1'b1})
    end
    apb(1'b1, SWC_WAKE_EN_OFS, 32'h0);
    do_sleep();
    @(posedge mclk_i);
    periph_wake_flag_i <= 9'h1ff;
    repeat (5) @(posedge mclk_i);
    #1;
    `CHK(wake_o, 1'b0)
    apb(1'b1, SWC_WAKE_EN_OFS, 32'h7ff);
    `CHK(wake_o, 1'b1)
    settle();
    do_sleep();
    periph_wake_flag_i <= 9'h002;
    #1;
    `CHK({osc_drive_o, power_down_flag_o, timeout_flag_o, wake_o}, 4'b0011)
    settle();
    apb(1'b1, SWC_CTRL_OFS, 32'h1);
    do_sleep();
    wait_wake();
    `CHK(wake_o, 1'b1)
    repeat (2) @(posedge mclk_i);
    apb(1'b0, SWC_SLEEP_STAT_OFS, 32'h0);
    `CHK(rd, stat(1'b0, 1'b0))
    apb(1'b1, SWC_CTRL_OFS, 32'h0);
    do_sleep();
    @(posedge mclk_i);
    master_clear_pin_n_i <= 1'b0;
    repeat (10) @(posedge mclk_i);
    #1;
    `CHK({core_reset_o, wake_o}, 2'b10)
    @(posedge mclk_i);
    master_clear_pin_n_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    #1;
    `CHK({core_reset_o, osc_drive_o}, 2'b01)
    end_sim();
  end
endmodule
bind swc_sleep_ctrl swc_chk #(.WDT_CYCLES(WDT_CYCLES)) u_chk (.*);
